// *** csds_defs.svh ***
// constants of the clock switch / deep sleep controller: offsets, fields, resets, timing
// assumes inclusion by the package and the modules of this block only
`ifndef CSDS_DEFS_SVH
`define CSDS_DEFS_SVH

// register offsets on the plain register port
`define CSDS_A_OSC   4'h0
`define CSDS_A_TUNE  4'h1
`define CSDS_A_T1    4'h2
`define CSDS_A_WDT   4'h3
`define CSDS_A_DSH   4'h4
`define CSDS_A_DSL   4'h5
`define CSDS_A_WAKE  4'h6
`define CSDS_A_GPR0  4'h7
`define CSDS_A_GPR1  4'h8
`define CSDS_A_DIR   4'h9
`define CSDS_A_LAT   4'ha

// field positions
`define CSDS_F_SCS    1:0
`define CSDS_F_STARTUP_TIMEOUT_STATUS   3
`define CSDS_F_IFS    6:4
`define CSDS_F_IDLE   7
`define CSDS_F_LFSRC  7
`define CSDS_F_SXEN   3
`define CSDS_F_SRUN   6
`define CSDS_F_REGULATOR_SLEEP 7
`define CSDS_F_DEEP_SLEEP_ENABLE   7
`define CSDS_F_RTCEN  0
`define CSDS_F_REL    0

// wake event bit positions
`define CSDS_W_MASTER_CLEAR  0
`define CSDS_W_RTC   1
`define CSDS_W_EXT_INTERRUPT_ZERO  2
`define CSDS_W_ULP   3
`define CSDS_W_DEEP_SLEEP_WATCHDOG 4

// clock sources and frequency codes
`define CSDS_SRC_PRI 2'h0
`define CSDS_SRC_SEC 2'h1
`define CSDS_SRC_INT 2'h2
`define CSDS_IFS_RST 3'h6
`define CSDS_IFS_LF  3'h0
`define CSDS_IFS_MAX 3'h7

// reset values
`define CSDS_DIR_RST    8'hff
`define CSDS_LAT_RST    8'h00
`define CSDS_REGULATOR_SLEEP_RST 1'h1

// timing
`define CSDS_CLK_NS    25
`define CSDS_POR_NS    1000
`define CSDS_POR_CYC   ((`CSDS_POR_NS + `CSDS_CLK_NS - 1) / `CSDS_CLK_NS)
`define CSDS_DEEP_SLEEP_ENABLE_LIFE 2'h2
`define CSDS_SW_OLD    3'h2
`define CSDS_SW_NEW    3'h3
`define CSDS_OST_TICKS 1024

`endif

// *** csds_pkg.sv ***
// types of the clock switch / deep sleep controller
// assumes csds_defs.svh on the include path
`include "csds_defs.svh"
package csds_pkg;
    typedef enum logic [2:0] {PM_RUN, PM_IDLE, PM_SLEEP, PM_DEEP, PM_POR} csds_pm_t;
    typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} csds_sw_t;

    typedef struct packed {
        csds_sw_t   state;
        logic [1:0] active;
        logic [1:0] pend;
        logic [2:0] cnt;
    } csds_sw_st_t;

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic [3:0]  prev;
        logic [7:0]  ps_cnt;
        logic [1:0]  sys_clk_select;
        logic [2:0]  ifs;
        logic        idle;
        logic        lfsrc;
        logic        sxen;
        logic        regulator_sleep;
        logic        dse;
        logic [1:0]  dse_cnt;
        logic        rtc_en;
        logic        hold;
        logic [4:0]  wake_low;
        logic [7:0]  gpr0;
        logic [7:0]  gpr1;
        logic [7:0]  dir;
        logic [7:0]  lat;
        logic [7:0]  hdir;
        logic [7:0]  hlat;
        logic [10:0] ost_cnt;
        logic        ost_done;
        csds_pm_t    pm;
        logic [7:0]  por_cnt;
        logic [7:0]  rdata;
    } csds_st_t;
endpackage : csds_pkg

// *** csds_sw_if.sv ***
// carrier between the controller and its clock switch sequencer
// assumes both ends on the same clock
interface csds_sw_if;
    logic [2:0] tick;
    logic [1:0] target;
    logic [1:0] active;
    logic       busy;
    logic       dev_tick;
    modport ctrl (output tick, output target, input active, input busy, input dev_tick);
    modport seq  (input tick, input target, output active, output busy, output dev_tick);
endinterface : csds_sw_if

// *** csds_sw_seq.sv ***
// glitch-free clock switch sequencer: stalls the device clock across a source change
// assumes source ticks are single-cycle pulses on clock, and the new source is stable
`include "csds_defs.svh"
module csds_sw_seq
    import csds_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic ce,
    csds_sw_if.seq    sw
);
    csds_sw_st_t st;
    csds_sw_st_t n;
    logic        old_t;
    logic        new_t;

    always_comb
    begin
        n     = st;
        old_t = sw.tick[st.active];
        new_t = sw.tick[st.pend];
        case (st.state)
            SW_RUN:
            begin
                if (sw.target != st.active)
                begin
                    n.state = SW_OLD;
                    n.pend  = sw.target;
                    n.cnt   = 3'h0;
                end
            end
            SW_OLD:
            begin
                if (old_t)
                begin
                    n.cnt = st.cnt + 3'h1;
                    if (st.cnt + 3'h1 == `CSDS_SW_OLD) // RULE13
                    begin
                        n.state = SW_NEW;
                        n.cnt   = 3'h0;
                    end
                end
            end
            SW_NEW:
            begin
                if (new_t)
                begin
                    n.cnt = st.cnt + 3'h1;
                    if (st.cnt + 3'h1 == `CSDS_SW_NEW) // RULE13
                    begin
                        n.state  = SW_RUN;
                        n.active = st.pend;
                    end
                end
            end
            default:
            begin
                n.state = SW_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '{state: SW_RUN, active: `CSDS_SRC_PRI, pend: `CSDS_SRC_PRI, cnt: 3'h0};
        end
        else if (ce)
        begin
            st <= n;
        end
    end

    assign sw.active   = st.active;
    assign sw.busy     = st.state != SW_RUN;
    assign sw.dev_tick = (st.state == SW_RUN) && sw.tick[st.active]; // RULE13

    a_switch_pause: assert property (@(posedge clock) disable iff (!nrst) // RULE13
        ce && st.state == SW_RUN && sw.target != st.active |=> sw.busy && !sw.dev_tick)
        else $error("source change did not pause the device clock");
endmodule : csds_sw_seq

// *** csds_ctrl.sv ***
// clock source selection, postscaler, power-managed mode control, deep sleep pin hold
// assumes oscillator pins asynchronous; core strobes and wake events on clock
// Functional notes
// RULE1: select field picks primary, secondary or internal
// RULE2: select write switches source after transition
// RULE3: every device reset clears select field
// RULE4: frequency field sets postscaled internal clock
// RULE5: frequency change takes effect at once
// RULE6: device reset returns postscaler to 4 MHz
// RULE7: code 000 uses divided fast or RC
// RULE8: watchdog and monitor always use RC
// RULE9: startup status when timer done on primary
// RULE10: secondary running status, at most one
// RULE11: sleep instruction: idle bit picks idle/sleep
// RULE12: secondary select ignored unless driver or digital
// RULE13: glitch-free switch, two old three new
// RULE14: software sets deep sleep then sleeps next
// RULE15: deep sleep enable self-clears after two cycles
// RULE16: deep sleep entry clears wake register
// RULE17: wake event leaves deep sleep via reset
// RULE18: two retention registers survive deep sleep
// RULE19: pins keep entry direction and level
// RULE20: pins held until firmware clears release
// RULE21: brownout trip releases pins, clears retention
// RULE22: master clear releases pins, keeps retention
//
// Design decisions made here: strobed register access and the placing of the registers.
`include "csds_defs.svh"
module csds_ctrl
    import csds_pkg::*;
#(
    parameter int OST_TICKS = `CSDS_OST_TICKS
)
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [3:0] osc_pins,
    input  wire logic       primary_osc_cfg,
    input  wire logic       secondary_digital_cfg,
    input  wire logic       dev_reset,
    input  wire logic       instr_tick,
    input  wire logic       sleep_exec,
    input  wire logic       pm_wake,
    input  wire logic [4:0] ds_wake_evt,
    input  wire logic       brownout_enable,
    input  wire logic       brownout_trip,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            cpu_clk_tick,
    output logic            periph_clk_tick,
    output logic            wdt_clk_tick,
    output logic            failsafe_clk_monitor_clk_tick,
    output logic            core_reset,
    output logic            idle_mode,
    output logic            sleep_mode,
    output logic            deep_sleep_mode,
    output logic            calendar_run,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe
);
    localparam logic [10:0] OST_LAST = 11'(OST_TICKS - 1);
    localparam logic [7:0]  POR_LAST = 8'(`CSDS_POR_CYC - 1);

    csds_st_t  st;
    csds_st_t  n;
    csds_sw_if sw ();
    logic [3:0] osc_tick;
    logic       int_tick;
    logic       core_rst;
    logic       sec_ok;
    logic       ds_go;
    logic       startup_timeout_status;
    logic       secondary_running;
    logic [7:0] osc_rd;
    logic [7:0] ps;

    // edge detect on the synchronised oscillator pins: 0 primary, 1 secondary, 2 fast, 3 rc
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_osc
            assign osc_tick[g] = st.sync2[g] & ~st.prev[g];
        end
    endgenerate

    // postscaler taps on the fast oscillator; code 000 with lfsrc clear takes the rc oscillator
    always_comb
    begin
        ps = st.ps_cnt;
        case (st.ifs) // RULE4 RULE5
            3'h7:    int_tick = osc_tick[2];
            3'h6:    int_tick = osc_tick[2] & ps[0];
            3'h5:    int_tick = osc_tick[2] & (&ps[1:0]);
            3'h4:    int_tick = osc_tick[2] & (&ps[2:0]);
            3'h3:    int_tick = osc_tick[2] & (&ps[3:0]);
            3'h2:    int_tick = osc_tick[2] & (&ps[4:0]);
            3'h1:    int_tick = osc_tick[2] & (&ps[5:0]);
            default: int_tick = st.lfsrc ? (osc_tick[2] & (&ps)) : osc_tick[3]; // RULE7
        endcase
    end

    assign sw.tick   = {int_tick, osc_tick[1], osc_tick[0]};
    assign sw.target = st.sys_clk_select[1] ? `CSDS_SRC_INT : st.sys_clk_select; // RULE1 RULE2

    csds_sw_seq csds_sw_seq_inst (
        .clock (clock),
        .nrst  (nrst),
        .ce    (ce),
        .sw    (sw.seq)
    );

    assign core_rst = dev_reset || (st.pm == PM_POR);
    assign sec_ok   = st.sxen || secondary_digital_cfg;
    assign ds_go    = st.dse && st.regulator_sleep && !st.idle; // RULE14
    assign startup_timeout_status = st.ost_done && primary_osc_cfg && !sw.busy
                                    && (sw.active == `CSDS_SRC_PRI); // RULE9
    assign secondary_running = !sw.busy && (sw.active == `CSDS_SRC_SEC); // RULE10

    always_comb
    begin
        osc_rd = 8'h00;
        osc_rd[`CSDS_F_SCS]  = st.sys_clk_select;
        osc_rd[`CSDS_F_STARTUP_TIMEOUT_STATUS] = startup_timeout_status;
        osc_rd[`CSDS_F_IFS]  = st.ifs;
        osc_rd[`CSDS_F_IDLE] = st.idle;
    end

    always_comb
    begin
        n       = st;
        n.sync1 = osc_pins;
        n.sync2 = st.sync1;
        n.prev  = st.sync2;
        if (osc_tick[2])
        begin
            n.ps_cnt = st.ps_cnt + 8'h01;
        end

        // startup timer counts primary ticks after each device reset
        if (osc_tick[0] && !st.ost_done)
        begin
            n.ost_cnt = st.ost_cnt + 11'h001;
            if (st.ost_cnt == OST_LAST)
            begin
                n.ost_done = 1'b1;
            end
        end

        // deep sleep enable lives two instruction cycles
        if (st.dse && instr_tick)
        begin
            n.dse_cnt = st.dse_cnt + 2'h1;
            if (st.dse_cnt + 2'h1 == `CSDS_DEEP_SLEEP_ENABLE_LIFE)
            begin
                n.dse = 1'b0; // RULE15
            end
        end

        // register writes
        if (wr && !core_rst)
        begin
            case (addr)
                `CSDS_A_OSC:
                begin
                    if (!(wdata[`CSDS_F_SCS] == `CSDS_SRC_SEC && !sec_ok)) // RULE12
                    begin
                        n.sys_clk_select = wdata[`CSDS_F_SCS]; // RULE2
                    end
                    n.ifs  = wdata[`CSDS_F_IFS]; // RULE5
                    n.idle = wdata[`CSDS_F_IDLE];
                end
                `CSDS_A_TUNE: n.lfsrc  = wdata[`CSDS_F_LFSRC];
                `CSDS_A_T1:   n.sxen   = wdata[`CSDS_F_SXEN];
                `CSDS_A_WDT:  n.regulator_sleep = wdata[`CSDS_F_REGULATOR_SLEEP];
                `CSDS_A_DSH:
                begin
                    n.rtc_en = wdata[`CSDS_F_RTCEN];
                    if (wdata[`CSDS_F_DEEP_SLEEP_ENABLE])
                    begin
                        n.dse     = 1'b1;
                        n.dse_cnt = 2'h0;
                    end
                end
                `CSDS_A_DSL:
                begin
                    if (!wdata[`CSDS_F_REL])
                    begin
                        n.hold = 1'b0; // RULE20
                    end
                end
                `CSDS_A_GPR0: n.gpr0 = wdata; // RULE18
                `CSDS_A_GPR1: n.gpr1 = wdata; // RULE18
                `CSDS_A_DIR:  n.dir  = wdata;
                `CSDS_A_LAT:  n.lat  = wdata;
                default:
                begin
                end
            endcase
        end

        // power-managed mode sequencing
        case (st.pm)
            PM_RUN:
            begin
                if (sleep_exec && !dev_reset)
                begin
                    if (ds_go)
                    begin
                        n.pm       = PM_DEEP;
                        n.wake_low = 5'h00; // RULE16
                        n.hold     = 1'b1;  // RULE19
                        n.hdir     = st.dir;
                        n.hlat     = st.lat;
                        n.dse      = 1'b0;
                    end
                    else
                    begin
                        n.pm = st.idle ? PM_IDLE : PM_SLEEP; // RULE11 RULE15
                    end
                end
            end
            PM_IDLE, PM_SLEEP:
            begin
                if (pm_wake)
                begin
                    n.pm = PM_RUN;
                end
            end
            PM_DEEP:
            begin
                if (|ds_wake_evt)
                begin
                    n.wake_low = st.wake_low | ds_wake_evt;
                    n.pm       = PM_POR; // RULE17
                    n.por_cnt  = 8'h00;
                    if (ds_wake_evt[`CSDS_W_MASTER_CLEAR])
                    begin
                        n.hold = 1'b0; // RULE22
                    end
                end
            end
            PM_POR:
            begin
                n.por_cnt = st.por_cnt + 8'h01;
                if (st.por_cnt == POR_LAST)
                begin
                    n.pm = PM_RUN;
                end
            end
            default: n.pm = PM_RUN;
        endcase

        // any device reset, including the one after deep sleep wake
        if (core_rst)
        begin
            n.sys_clk_select      = `CSDS_SRC_PRI;  // RULE3
            n.ifs      = `CSDS_IFS_RST;  // RULE6
            n.idle     = 1'b0;
            n.lfsrc    = 1'b0;
            n.sxen     = 1'b0;
            n.regulator_sleep   = `CSDS_REGULATOR_SLEEP_RST;
            n.dse      = 1'b0;
            n.dir      = `CSDS_DIR_RST;  // RULE20
            n.lat      = `CSDS_LAT_RST;
            n.ost_cnt  = 11'h000;
            n.ost_done = 1'b0;
            if (dev_reset && st.pm != PM_DEEP && st.pm != PM_POR)
            begin
                n.pm = PM_RUN;
            end
        end

        // brownout trip loses every held value
        if (brownout_enable && brownout_trip)
        begin
            n.hold = 1'b0; // RULE21
            n.gpr0 = 8'h00;
            n.gpr1 = 8'h00;
            if (st.pm == PM_DEEP)
            begin
                n.pm      = PM_POR;
                n.por_cnt = 8'h00;
            end
        end

        // read data stand in the cycle after the strobe
        n.rdata = 8'h00;
        if (rd)
        begin
            case (addr)
                `CSDS_A_OSC:  n.rdata = osc_rd;
                `CSDS_A_TUNE: n.rdata = {st.lfsrc, 7'h00};
                `CSDS_A_T1:   n.rdata = {1'b0, secondary_running, 2'h0, st.sxen, 3'h0}; // RULE10
                `CSDS_A_WDT:  n.rdata = {st.regulator_sleep, 7'h00};
                `CSDS_A_DSH:  n.rdata = {st.dse, 6'h00, st.rtc_en};
                `CSDS_A_DSL:  n.rdata = {7'h00, st.hold};
                `CSDS_A_WAKE: n.rdata = {3'h0, st.wake_low};
                `CSDS_A_GPR0: n.rdata = st.gpr0;
                `CSDS_A_GPR1: n.rdata = st.gpr1;
                `CSDS_A_DIR:  n.rdata = st.dir;
                `CSDS_A_LAT:  n.rdata = st.lat;
                default:      n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st          <= '0;
            st.ifs      <= `CSDS_IFS_RST;
            st.regulator_sleep   <= `CSDS_REGULATOR_SLEEP_RST;
            st.dir      <= `CSDS_DIR_RST;
            st.pm       <= PM_RUN;
        end
        else if (ce)
        begin
            st <= n;
        end
    end

    assign rdata           = st.rdata;
    assign cpu_clk_tick    = sw.dev_tick && (st.pm == PM_RUN);
    assign periph_clk_tick = sw.dev_tick && (st.pm == PM_RUN || st.pm == PM_IDLE);
    assign wdt_clk_tick    = osc_tick[3]; // RULE8
    assign failsafe_clk_monitor_clk_tick   = osc_tick[3]; // RULE8
    assign core_reset      = core_rst;
    assign idle_mode       = st.pm == PM_IDLE;
    assign sleep_mode      = st.pm == PM_SLEEP;
    assign deep_sleep_mode = st.pm == PM_DEEP;
    assign calendar_run    = st.rtc_en; // RULE16
    assign pin_out         = st.hold ? st.hlat : st.lat;   // RULE19 RULE20
    assign pin_oe          = st.hold ? ~st.hdir : ~st.dir; // RULE19 RULE20

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_select_reset: assert property (ce && dev_reset && !(brownout_enable && brownout_trip) |=> st.sys_clk_select == 2'h0) // RULE3
        else $error("select field not cleared by reset");
    a_freq_reset: assert property (ce && dev_reset |=> st.ifs == `CSDS_IFS_RST) // RULE6
        else $error("postscaler not back at reset code");
    a_sec_refused: assert property (ce && wr && !core_rst && addr == `CSDS_A_OSC
        && wdata[`CSDS_F_SCS] == `CSDS_SRC_SEC && !sec_ok |=> st.sys_clk_select == $past(st.sys_clk_select)) // RULE12
        else $error("secondary select taken without driver");
    a_dse_expire: assert property (ce && st.dse && instr_tick && st.dse_cnt == 2'h1
        && !(wr && addr == `CSDS_A_DSH) |=> !st.dse) // RULE15
        else $error("deep sleep enable outlived two cycles");
    a_deep_entry: assert property (ce && st.pm == PM_RUN && sleep_exec && !dev_reset && ds_go
        && !(brownout_enable && brownout_trip) |=> st.pm == PM_DEEP && st.hold && st.wake_low == 5'h00) // RULE16
        else $error("deep sleep entry incomplete");
    a_idle_pick: assert property (ce && st.pm == PM_RUN && sleep_exec && !dev_reset && !ds_go
        |=> st.pm == ($past(st.idle) ? PM_IDLE : PM_SLEEP)) // RULE11
        else $error("sleep instruction chose wrong mode");
    a_master_clear_release: assert property (ce && st.pm == PM_DEEP && ds_wake_evt[`CSDS_W_MASTER_CLEAR]
        && !(brownout_enable && brownout_trip) |=> !st.hold && st.pm == PM_POR && st.gpr0 == $past(st.gpr0)) // RULE22
        else $error("master clear wake did not release pins");
    a_bor_loss: assert property (ce && brownout_enable && brownout_trip
        |=> !st.hold && st.gpr0 == 8'h00 && st.gpr1 == 8'h00) // RULE21
        else $error("brownout left held state");
    a_pins_held: assert property (ce && st.pm == PM_DEEP && !(|ds_wake_evt) && !brownout_trip
        |=> pin_out == $past(pin_out) && pin_oe == $past(pin_oe)) // RULE19
        else $error("pins moved during deep sleep");
    a_one_status: assert property (!(startup_timeout_status && secondary_running)) // RULE10
        else $error("two source status bits set");
endmodule : csds_ctrl

// *** csds_ctrl_test.sv ***
// testbench of the clock switch / deep sleep controller: register tasks and scenarios
// assumes csds_defs.svh on the include path and csds_pkg compiled before
`include "csds_defs.svh"
module csds_ctrl_test
    import csds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock, nrst, dev_reset, instr_tick, sleep_exec, pm_wake, brownout_enable, brownout_trip, wr, rd;
    logic       cpu_clk_tick, periph_clk_tick, wdt_clk_tick, failsafe_clk_monitor_clk_tick, core_reset, sdig;
    logic       idle_mode, sleep_mode, deep_sleep_mode, calendar_run;
    logic [7:0] rdata, pin_out, pin_oe, wdata;
    logic [4:0] ds_wake_evt;
    logic [3:0] addr, osc_pins;
    logic [8:0] oc;
    int         err_total, checked, k;
    integer     ca, cb, cf, cp;

    csds_ctrl #(.OST_TICKS(8)) csds_ctrl_inst (.clock, .nrst, .ce(1'b1), .osc_pins, .primary_osc_cfg(1'b1),
        .secondary_digital_cfg(sdig), .dev_reset, .instr_tick, .sleep_exec, .pm_wake, .ds_wake_evt,
        .brownout_enable, .brownout_trip, .addr, .wdata, .wr, .rd, .rdata, .cpu_clk_tick, .periph_clk_tick,
        .wdt_clk_tick, .failsafe_clk_monitor_clk_tick, .core_reset, .idle_mode, .sleep_mode, .deep_sleep_mode,
        .calendar_run, .pin_out, .pin_oe);

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // oscillators: primary /4, secondary /16, fast /2, rc /32
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            oc       <= 9'h000;
            osc_pins <= 4'h0;
        end
        else
        begin
            oc       <= oc + 9'h001;
            osc_pins <= {oc[4], oc[0], oc[3], oc[1]};
        end
    end

    task test_done;
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wreg

    task rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp, input string nm);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(nm, rdata & m, exp);
    endtask : rchk

    task pulse_sleep;
        @(posedge clock);
        sleep_exec <= 1'b1;
        @(posedge clock);
        sleep_exec <= 1'b0;
        @(posedge clock);
        #1;
    endtask : pulse_sleep

    // counts device and watchdog ticks over one 512-cycle period of the oscillator counter
    task win;
        repeat (512) if (oc !== 9'h0)
        begin
            @(posedge clock);
            #1;
        end
        ca = 0;
        cb = 0;
        cf = 0;
        cp = 0;
        repeat (512)
        begin
            @(posedge clock);
            #1;
            ca += cpu_clk_tick;
            cb += wdt_clk_tick;
            cf += failsafe_clk_monitor_clk_tick;
            cp += periph_clk_tick;
        end
    endtask : win

    task wake(input logic [4:0] evt, input logic bo);
        int i;
        @(posedge clock);
        ds_wake_evt <= evt;
        brownout_enable <= bo;
        brownout_trip <= bo;
        @(posedge clock);
        ds_wake_evt <= 5'h0;
        brownout_trip <= 1'b0;
        @(posedge clock);
        #1;
        chk("por", core_reset, 1'b1);
        for (i = 0; i < 100 && core_reset !== 1'b0; i++)
        begin
            @(posedge clock);
            #1;
        end
        if (i == 100)
        begin
            err_total++;
            test_done;
        end
    endtask : wake

    task enter_deep;
        wreg(`CSDS_A_DSH, 8'h81);
        pulse_sleep;
        chk("deep", deep_sleep_mode, 1'b1);
        chk("cal", calendar_run, 1'b1);
    endtask : enter_deep

    initial
    begin
        {nrst, dev_reset, instr_tick, sleep_exec, pm_wake, brownout_enable, brownout_trip, wr, rd} = '0;
        {wdata, ds_wake_evt, addr, sdig, err_total, checked} = '0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rchk(`CSDS_A_OSC, 8'hf7, 8'h60, "osc_rst");
        rchk(`CSDS_A_WDT, 8'hff, 8'h80, "wdt_rst");
        rchk(`CSDS_A_DIR, 8'hff, 8'hff, "dir_rst");
        rchk(4'hf, 8'hff, 8'h00, "unmapped");
        repeat (200) @(posedge clock);
        rchk(`CSDS_A_OSC, 8'h08, 8'h08, "startup");
        wreg(`CSDS_A_OSC, 8'h61);
        rchk(`CSDS_A_OSC, 8'h03, 8'h00, "sec_refused");
        wreg(`CSDS_A_T1, 8'h08);
        wreg(`CSDS_A_OSC, 8'h61);
        repeat (200) @(posedge clock);
        rchk(`CSDS_A_OSC, 8'h0b, 8'h01, "sec_sel");
        rchk(`CSDS_A_T1, 8'h40, 8'h40, "sec_run");
        for (k = 0; k < 4; k++)
        begin
            wreg(`CSDS_A_TUNE, (k == 3) ? 8'h80 : 8'h00);
            wreg(`CSDS_A_OSC, {1'b0, (k == 0) ? 3'h7 : (k == 1) ? 3'h6 : 3'h0, 4'h2});
            repeat (100) @(posedge clock);
            win;
            chk("int_ticks", ca, (k == 0) ? 256 : (k == 1) ? 128 : (k == 2) ? 16 : 1);
            chk("wdt_ticks", cb, 16);
            chk("failsafe_clk_monitor_ticks", cf, 16);
            chk("periph_ticks", cp, (k == 0) ? 256 : (k == 1) ? 128 : (k == 2) ? 16 : 1);
        end
        wreg(`CSDS_A_OSC, 8'h80);
        pulse_sleep;
        chk("idle", {idle_mode, sleep_mode}, 2'h2);
        wreg(`CSDS_A_OSC, 8'h00);
        @(posedge clock);
        pm_wake <= 1'b1;
        @(posedge clock);
        pm_wake <= 1'b0;
        pulse_sleep;
        chk("sleep", {idle_mode, sleep_mode}, 2'h1);
        @(posedge clock);
        pm_wake <= 1'b1;
        @(posedge clock);
        pm_wake <= 1'b0;
        wreg(`CSDS_A_DSH, 8'h80);
        rchk(`CSDS_A_DSH, 8'h80, 8'h80, "dse_set");
        repeat (2)
        begin
            @(posedge clock);
            instr_tick <= 1'b1;
            @(posedge clock);
            instr_tick <= 1'b0;
        end
        rchk(`CSDS_A_DSH, 8'h80, 8'h00, "dse_clr");
        wreg(`CSDS_A_GPR0, 8'ha5);
        wreg(`CSDS_A_GPR1, 8'h5a);
        wreg(`CSDS_A_DIR, 8'hf0);
        wreg(`CSDS_A_LAT, 8'h0f);
        enter_deep;
        chk("pin_oe", pin_oe, 8'h0f);
        chk("pin_out", pin_out & pin_oe, 8'h0f);
        wake(5'h02, 1'b0);
        rchk(`CSDS_A_WAKE, 8'h1f, 8'h02, "wake_src");
        rchk(`CSDS_A_DSL, 8'h01, 8'h01, "held");
        rchk(`CSDS_A_DIR, 8'hff, 8'hff, "dir_por");
        chk("pin_hold", {pin_oe, pin_out & pin_oe}, 16'h0f0f);
        rchk(`CSDS_A_GPR0, 8'hff, 8'ha5, "gpr0");
        rchk(`CSDS_A_GPR1, 8'hff, 8'h5a, "gpr1");
        wreg(`CSDS_A_DSL, 8'h00);
        @(posedge clock);
        #1;
        chk("pin_rel", pin_oe, 8'h00);
        wreg(`CSDS_A_DIR, 8'h00);
        enter_deep;
        wake(5'h01, 1'b0);
        rchk(`CSDS_A_WAKE, 8'h1f, 8'h01, "wake_master_clear");
        rchk(`CSDS_A_DSL, 8'h01, 8'h00, "master_clear_rel");
        rchk(`CSDS_A_GPR0, 8'hff, 8'ha5, "master_clear_gpr");
        wreg(`CSDS_A_DIR, 8'h00);
        enter_deep;
        wake(5'h00, 1'b1);
        rchk(`CSDS_A_GPR0, 8'hff, 8'h00, "bo_gpr");
        rchk(`CSDS_A_DSL, 8'h01, 8'h00, "bo_rel");
        wreg(`CSDS_A_GPR0, 8'h3c);
        wreg(`CSDS_A_OSC, 8'h72);
        @(posedge clock);
        dev_reset <= 1'b1;
        @(posedge clock);
        dev_reset <= 1'b0;
        rchk(`CSDS_A_OSC, 8'hf3, 8'h60, "dev_rst");
        rchk(`CSDS_A_GPR0, 8'hff, 8'h3c, "dev_gpr");
        @(posedge clock);
        sdig <= 1'b1;
        wreg(`CSDS_A_OSC, 8'h61);
        rchk(`CSDS_A_OSC, 8'h03, 8'h01, "sec_dig");
        test_done;
    end
endmodule : csds_ctrl_test
